// [rtl/ir_timer_pkg.sv]
/*
  ir_timer_pkg: bank D offsets, control field positions, reset values,
  modes and prescale codes for the byte timer and word timer capture block.
  Assumes a single system clock and an 8-bit register file port.
*/
package ir_timer_pkg;

  localparam logic [7:0] BANK_POINTER_ADDR = 8'hfd;
  localparam logic [3:0] BANK_D_SEL        = 4'hd;
  localparam logic [3:0] BANK_NORMAL       = 4'h0;
  localparam logic [3:0] EXP_WINDOW_HI     = 4'h0;

  localparam logic [3:0] OFF_BT_CONTROL    = 4'h0;
  localparam logic [3:0] OFF_SHARED_CTRL   = 4'h1;
  localparam logic [3:0] OFF_BT_LOW_HOLD   = 4'h4;
  localparam logic [3:0] OFF_BT_HIGH_HOLD  = 4'h5;
  localparam logic [3:0] OFF_WT_HOLD_LO    = 4'h6;
  localparam logic [3:0] OFF_WT_HOLD_HI    = 4'h7;
  localparam logic [3:0] OFF_WT_CAP_LO     = 4'h8;
  localparam logic [3:0] OFF_WT_CAP_HI     = 4'h9;
  localparam logic [3:0] OFF_BT_CAP_LO     = 4'ha;
  localparam logic [3:0] OFF_BT_CAP_HI     = 4'hb;

  localparam int CTL_RUN      = 7;
  localparam int CTL_ONESHOT  = 6;
  localparam int CTL_FLAG     = 5;
  localparam int CTL_PSC_HI   = 4;
  localparam int CTL_PSC_LO   = 3;
  localparam int CTL_CAP_IE   = 2;
  localparam int CTL_TO_IE    = 1;
  localparam int CTL_ROUTE    = 0;

  localparam int SHR_MODE     = 7;
  localparam int SHR_EDGE_HI  = 5;
  localparam int SHR_EDGE_LO  = 4;
  // shared control bits kept over stop-mode recovery
  localparam logic [7:0] SHR_SMR_KEEP = 8'h30;

  localparam logic [7:0]  BYTE_ZERO  = 8'h00;
  localparam logic [7:0]  BYTE_ONES  = 8'hff;
  localparam logic [7:0]  BYTE_ONE   = 8'h01;
  localparam logic [15:0] WORD_ZERO  = 16'h0000;
  localparam logic [15:0] WORD_ONE   = 16'h0001;

  typedef enum logic [1:0] {
    PSC_DIV1,
    PSC_DIV2,
    PSC_DIV4,
    PSC_DIV8
  } prescale_t;

  localparam logic [2:0] DIV2_MASK = 3'h1;
  localparam logic [2:0] DIV4_MASK = 3'h3;
  localparam logic [2:0] DIV8_MASK = 3'h7;
  localparam logic [2:0] DIV_ZERO  = 3'h0;
  localparam logic [2:0] DIV_STEP  = 3'h1;

  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h2;

endpackage

// [rtl/timer_prescaler.sv]
/*
  timer_prescaler: free-running divider giving a one-cycle tick at the
  system clock rate divided by 1, 2, 4 or 8.
  Assumes the select comes from a register on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
module timer_prescaler
  import ir_timer_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [1:0] sel,
  output logic            tick
);

  logic [2:0] div_q;
  logic [2:0] div_mask;

  // free running, so the first tick after a start is not aligned
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= DIV_ZERO;
    end else begin
      div_q <= div_q + DIV_STEP;
    end
  end

  assign div_mask = (sel == PSC_DIV2) ? DIV2_MASK :
                    (sel == PSC_DIV4) ? DIV4_MASK :
                    (sel == PSC_DIV8) ? DIV8_MASK : DIV_ZERO;
  assign tick     = ((div_q & div_mask) == DIV_ZERO);

endmodule
`default_nettype wire

// [rtl/ir_timer_capture_control.sv]
/*
  ir_timer_capture_control: byte timer control, level hold and capture
  registers plus word timer hold and capture bytes, reached through the
  bank pointer in the expanded bank space.
  Assumes a CPU register port on clk and an asynchronous capture pin.
*/
`timescale 1ns/10ps
`default_nettype none
module ir_timer_capture_control
  import ir_timer_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       stop_recovery,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic [7:0]      reg_rdata,
  output logic            reg_hit,
  input  wire logic       capture_in,
  input  wire logic       port_out_data,
  output logic            timer_output_pin,
  output logic            capture_irq,
  output logic            timeout_irq
);

  function automatic logic [7:0] reload_value(input logic lvl, input logic [7:0] lo,
                                              input logic [7:0] hi);
    reload_value = lvl ? hi : lo;
  endfunction

  logic [7:0]  bank_pointer_q;
  logic        run_q, oneshot_q, flag_q, cap_ie_q, to_ie_q, route_q;
  logic [1:0]  prescale_q;
  logic [7:0]  shared_ctrl_q;
  logic [7:0]  low_hold_q, high_hold_q, wt_hold_lo_q, wt_hold_hi_q;
  logic [7:0]  cap_lo_q, cap_hi_q, wt_cap_lo_q, wt_cap_hi_q;
  logic [7:0]  count_q;
  logic [15:0] word_count_q;
  logic        out_q, pin_q;
  logic        sync1_q, sync2_q, level_q;
  logic [7:0]  rdata_q;

  logic        in_bank_d, bp_sel, ctrl_wr, shr_wr, tick, demod, terminal;
  logic        rise, fall, edge_seen, start;
  logic [3:0]  off;
  logic [7:0]  ctrl_view, rd_mux;

  // bank D replaces the low sixteen registers
  assign off       = reg_addr[3:0];
  assign in_bank_d = (reg_addr[7:4] == EXP_WINDOW_HI)
                  && (bank_pointer_q[3:0] == BANK_D_SEL);
  assign bp_sel    = (reg_addr == BANK_POINTER_ADDR);
  assign ctrl_wr   = reg_wr && in_bank_d && (off == OFF_BT_CONTROL);
  assign shr_wr    = reg_wr && in_bank_d && (off == OFF_SHARED_CTRL);
  assign demod     = shared_ctrl_q[SHR_MODE];
  assign start     = ctrl_wr && reg_wdata[CTL_RUN] && !run_q;

  assign ctrl_view = {run_q, oneshot_q, flag_q, prescale_q, cap_ie_q, to_ie_q, route_q};

  assign reg_hit = bp_sel || (in_bank_d && (off <= OFF_BT_CAP_HI)
                   && (off != 4'h2) && (off != 4'h3));

  always_comb begin
    rd_mux = BYTE_ZERO;
    if (bp_sel) begin
      rd_mux = bank_pointer_q;
    end else if (in_bank_d) begin
      case (off)
        OFF_BT_CONTROL:   rd_mux = ctrl_view;
        OFF_SHARED_CTRL:  rd_mux = shared_ctrl_q;
        OFF_BT_LOW_HOLD:  rd_mux = low_hold_q;
        OFF_BT_HIGH_HOLD: rd_mux = high_hold_q;
        OFF_WT_HOLD_LO:   rd_mux = wt_hold_lo_q;
        OFF_WT_HOLD_HI:   rd_mux = wt_hold_hi_q;
        OFF_WT_CAP_LO:    rd_mux = wt_cap_lo_q;
        OFF_WT_CAP_HI:    rd_mux = wt_cap_hi_q;
        OFF_BT_CAP_LO:    rd_mux = cap_lo_q;
        OFF_BT_CAP_HI:    rd_mux = cap_hi_q;
        default:          rd_mux = BYTE_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= BYTE_ZERO;
    end else if (reg_rd) begin
      rdata_q <= rd_mux;
    end
  end
  assign reg_rdata = rdata_q;

  // prescaled tick, free running
  timer_prescaler u_prescaler (
    .clk   (clk),
    .rst_n (rst_n),
    .sel   (prescale_q),
    .tick  (tick)
  );

  // capture pin synchroniser, then edge detection on the clean copy
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      level_q <= 1'b0;
    end else begin
      sync1_q <= capture_in;
      sync2_q <= sync1_q;
      level_q <= sync2_q;
    end
  end

  assign rise      = sync2_q && !level_q;
  assign fall      = !sync2_q && level_q;
  assign edge_seen = demod && run_q && (
                     ((shared_ctrl_q[SHR_EDGE_HI:SHR_EDGE_LO] == EDGE_FALL) && fall) ||
                     ((shared_ctrl_q[SHR_EDGE_HI:SHR_EDGE_LO] == EDGE_RISE) && rise) ||
                     ((shared_ctrl_q[SHR_EDGE_HI:SHR_EDGE_LO] == EDGE_BOTH) && (rise || fall)));

  assign terminal  = run_q && tick && !start && (demod ? (count_q == BYTE_ONES)
                                                       : (count_q == BYTE_ZERO));

  // bank pointer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bank_pointer_q <= BYTE_ZERO;
    end else if (reg_wr && bp_sel) begin
      bank_pointer_q <= reg_wdata;
    end
  end

  // control bits cleared by both resets
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_q     <= 1'b0;
      oneshot_q <= 1'b0;
      route_q   <= 1'b0;
    end else if (stop_recovery) begin
      run_q     <= 1'b0;
      oneshot_q <= 1'b0;
      route_q   <= 1'b0;
    end else if (ctrl_wr) begin
      run_q     <= reg_wdata[CTL_RUN];
      oneshot_q <= reg_wdata[CTL_ONESHOT];
      route_q   <= reg_wdata[CTL_ROUTE];
    end else if (terminal && oneshot_q && !demod) begin
      run_q     <= 1'b0;
    end
  end

  // control bits kept over stop recovery
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_q     <= 1'b0;
      prescale_q <= PSC_DIV1;
      cap_ie_q   <= 1'b0;
      to_ie_q    <= 1'b0;
    end else begin
      if (terminal) begin
        flag_q <= 1'b1;
      end else if (ctrl_wr && reg_wdata[CTL_FLAG]) begin
        flag_q <= 1'b0;
      end
      if (ctrl_wr) begin
        prescale_q <= reg_wdata[CTL_PSC_HI:CTL_PSC_LO];
        cap_ie_q   <= reg_wdata[CTL_CAP_IE];
        to_ie_q    <= reg_wdata[CTL_TO_IE];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shared_ctrl_q <= BYTE_ZERO;
    end else if (stop_recovery) begin
      shared_ctrl_q <= shared_ctrl_q & SHR_SMR_KEEP;
    end else if (shr_wr) begin
      shared_ctrl_q <= reg_wdata;
    end
  end

  // hold registers, software owned
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      low_hold_q   <= BYTE_ZERO;
      high_hold_q  <= BYTE_ZERO;
      wt_hold_lo_q <= BYTE_ZERO;
      wt_hold_hi_q <= BYTE_ZERO;
    end else if (reg_wr && in_bank_d) begin
      if (off == OFF_BT_LOW_HOLD)  low_hold_q   <= reg_wdata;
      if (off == OFF_BT_HIGH_HOLD) high_hold_q  <= reg_wdata;
      if (off == OFF_WT_HOLD_LO)   wt_hold_lo_q <= reg_wdata;
      if (off == OFF_WT_HOLD_HI)   wt_hold_hi_q <= reg_wdata;
    end
  end

  // byte timer: down-counter in transmit, up-counter in demodulation
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= BYTE_ZERO;
      out_q   <= 1'b0;
    end else if (start) begin
      count_q <= demod ? BYTE_ZERO : low_hold_q;
      out_q   <= 1'b0;
    end else if (edge_seen) begin
      count_q <= BYTE_ZERO;
    end else if (terminal && !demod) begin
      count_q <= reload_value(!out_q, low_hold_q, high_hold_q);
      out_q   <= !out_q;
    end else if (run_q && tick) begin
      count_q <= demod ? count_q + BYTE_ONE : count_q - BYTE_ONE;
    end
  end

  // word timer measures in system clocks between capture edges
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      word_count_q <= WORD_ZERO;
    end else if (start || edge_seen) begin
      word_count_q <= WORD_ZERO;
    end else if (run_q && demod) begin
      word_count_q <= word_count_q + WORD_ONE;
    end
  end

  // capture registers only change on an edge, never by a write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cap_lo_q    <= BYTE_ZERO;
      cap_hi_q    <= BYTE_ZERO;
      wt_cap_lo_q <= BYTE_ZERO;
      wt_cap_hi_q <= BYTE_ZERO;
    end else if (edge_seen) begin
      if (level_q) begin
        cap_hi_q <= count_q;
      end else begin
        cap_lo_q <= count_q;
      end
      wt_cap_hi_q <= word_count_q[15:8];
      wt_cap_lo_q <= word_count_q[7:0];
    end
  end

  // requests in the recognition cycle
  assign capture_irq = edge_seen && cap_ie_q;
  assign timeout_irq = terminal && to_ie_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= route_q ? out_q : port_out_data;
    end
  end
  assign timer_output_pin = pin_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_bank_hold_write: assert property (
    reg_wr && in_bank_d && off == OFF_BT_LOW_HOLD |=> low_hold_q == $past(reg_wdata))
    else $error("low level hold not written");
  chk_bank_gate: assert property (
    reg_wr && !bp_sel && bank_pointer_q[3:0] != BANK_D_SEL |=> $stable(low_hold_q))
    else $error("hold written outside bank D");
  chk_capture_read_only: assert property (
    reg_wr && in_bank_d && off == OFF_BT_CAP_HI && !edge_seen |=> $stable(cap_hi_q))
    else $error("capture register changed by write");
  chk_capture_high_count: assert property (
    edge_seen && level_q |=> cap_hi_q == $past(count_q))
    else $error("high capture missed count");
  chk_capture_low_count: assert property (
    edge_seen && !level_q |=> cap_lo_q == $past(count_q))
    else $error("low capture missed count");
  chk_flag_set_terminal: assert property (
    terminal |=> flag_q)
    else $error("flag not set at terminal count");
  chk_flag_sticky_hold: assert property (
    flag_q && !(ctrl_wr && reg_wdata[CTL_FLAG]) |=> flag_q)
    else $error("flag cleared without write one");
  chk_oneshot_stop_run: assert property (
    terminal && oneshot_q && !demod && !ctrl_wr && !stop_recovery |=> !run_q)
    else $error("one-shot did not stop");
  chk_modulo_reload_value: assert property (
    terminal && !oneshot_q && !demod && !reg_wr && !stop_recovery
      |=> run_q && count_q == reload_value(out_q, low_hold_q, high_hold_q))
    else $error("modulo timer did not reload");
  chk_run_start_read: assert property (
    ctrl_wr && reg_wdata[CTL_RUN] && !stop_recovery |=> run_q)
    else $error("run not started");
  chk_timeout_irq_gate: assert property (
    timeout_irq |-> to_ie_q ##1 flag_q)
    else $error("timeout request without enable or flag");
  chk_capture_irq_gate: assert property (
    capture_irq |=> $past(cap_ie_q) && word_count_q == WORD_ZERO)
    else $error("capture request without capture");
  chk_pin_route_out: assert property (
    route_q |=> timer_output_pin == $past(out_q))
    else $error("pin not carrying timer output");
  chk_recovery_keep_bits: assert property (
    stop_recovery && !terminal |=> !run_q && flag_q == $past(flag_q)
      && prescale_q == $past(prescale_q))
    else $error("stop recovery touched kept bits");
  chk_prescale_div8_gap: assert property (
    tick && prescale_q == PSC_DIV8 && !ctrl_wr |=> (!tick || prescale_q != PSC_DIV8) [*7])
    else $error("divide by eight tick spacing wrong");

  cov_capture_high: cover property (edge_seen && level_q && cap_ie_q);
  cov_modulo_wrap: cover property (terminal && !oneshot_q ##[1:300] terminal);
  cov_oneshot_end: cover property (terminal && oneshot_q && !demod);
  cov_flag_set_wins: cover property (terminal && ctrl_wr && reg_wdata[CTL_FLAG]);

endmodule
`default_nettype wire

// [dv/tb.sv]
/*
  tb: self-checking bench for the byte timer control, hold and capture
  registers, driven through the register file port and the bank pointer.
  Assumes the design package and module from rtl/ are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module tb;
  import ir_timer_pkg::*;
  logic       clk;
  logic       rst_n;
  logic       stop_recovery;
  logic [7:0] reg_addr;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic       reg_hit;
  logic       capture_in;
  logic       port_out_data;
  logic       timer_output_pin;
  logic       capture_irq;
  logic       timeout_irq;
  int         bad_count;
  int         cmp_count;
  int         cyc;
  int         to_cnt;
  int         cap_cnt;
  int         c0;
  int         t1;
  int         t2;
  logic [7:0] d;
  logic [7:0] d2;
  logic       h;
  logic       a;

  ir_timer_capture_control ir_timer_capture_control_inst (
    .clk              (clk),
    .rst_n            (rst_n),
    .stop_recovery    (stop_recovery),
    .reg_addr         (reg_addr),
    .reg_wr           (reg_wr),
    .reg_rd           (reg_rd),
    .reg_wdata        (reg_wdata),
    .reg_rdata        (reg_rdata),
    .reg_hit          (reg_hit),
    .capture_in       (capture_in),
    .port_out_data    (port_out_data),
    .timer_output_pin (timer_output_pin),
    .capture_irq      (capture_irq),
    .timeout_irq      (timeout_irq)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // free-running cycle count and pulse tallies
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (timeout_irq === 1'b1) to_cnt <= to_cnt + 1;
    if (capture_irq === 1'b1) cap_cnt <= cap_cnt + 1;
  end

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic chk1(input logic g, input logic e);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic chk_rng(input logic [7:0] g, input int lo, input int hi);
    cmp_count++;
    if ($isunknown(g) || g < lo || g > hi) begin
      bad_count++;
      $display("BAD t=%0t got %h exp %h..%h", $time, g, lo, hi);
    end
  endtask

  task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
    @(posedge clk);
    #1;
    reg_addr  = ad;
    reg_wdata = dt;
    reg_wr    = 1'b1;
    @(posedge clk);
    #1;
    reg_wr = 1'b0;
  endtask

  // hit sampled at the taking edge, data just after that same edge
  task automatic rd(input logic [7:0] ad, output logic [7:0] dt, output logic hit);
    @(posedge clk);
    #1;
    reg_addr = ad;
    reg_rd   = 1'b1;
    @(posedge clk);
    hit = reg_hit;
    #1;
    reg_rd = 1'b0;
    dt     = reg_rdata;
  endtask

  task automatic rdchk(input logic [7:0] ad, input logic [7:0] e);
    logic [7:0] v;
    logic       hv;
    rd(ad, v, hv);
    chk8(v, e);
  endtask

  task automatic wait_pulse(input bit cap, output int at);
    at = -1;
    for (int i = 0; i < 400; i++) begin
      @(posedge clk);
      #2;
      if ((cap ? capture_irq : timeout_irq) === 1'b1) begin
        at = cyc;
        break;
      end
    end
    if (at < 0) chk1(1'b0, 1'b1);
  endtask

  initial begin
    #400000;
    bad_count++;
    final_report();
  end

  initial begin
    rst_n = 1'b0; stop_recovery = 1'b0; reg_addr = 8'h00; reg_wr = 1'b0;
    reg_rd = 1'b0; reg_wdata = 8'h00; capture_in = 1'b1; port_out_data = 1'b0;
    bad_count = 0; cmp_count = 0; cyc = 0; to_cnt = 0; cap_cnt = 0;
    repeat (10) @(posedge clk);
    #1;
    rst_n = 1'b1;
    rd(8'h04, d, h);
    chk1(h, 1'b0);
    wr(8'h04, 8'h55);
    wr(8'hfd, 8'h7d);
    rdchk(8'hfd, 8'h7d);
    for (int k = 0; k < 12; k++) begin
      rd(k[7:0], d, h);
      chk8(d, 8'h00);
      chk1(h, (k != 2 && k != 3));
    end
    for (int k = 4; k < 8; k++) wr(k[7:0], 8'h30 + k[7:0]);
    for (int k = 4; k < 8; k++) rdchk(k[7:0], 8'h30 + k[7:0]);
    wr(8'h04, 8'h04);
    wr(8'h05, 8'h04);
    wr(8'h00, 8'h20);
    for (int p = 0; p < 4; p++) begin
      wr(8'h00, 8'h83 | (p[7:0] << 3));
      wait_pulse(1'b0, t1);
      wait_pulse(1'b0, t2);
      chk_rng(8'(t2 - t1), 5 << p, 5 << p);
      repeat (2) @(posedge clk);
      #1;
      a = timer_output_pin;
      repeat (5 << p) @(posedge clk);
      #1;
      chk1(timer_output_pin, ~a);
      wr(8'h00, 8'h20);
    end
    wr(8'h04, 8'h02);
    wr(8'h00, 8'hc2);
    wait_pulse(1'b0, t1);
    repeat (4) @(posedge clk);
    rdchk(8'h00, 8'h62);
    wr(8'h00, 8'h40);
    rdchk(8'h00, 8'h60);
    wr(8'h00, 8'h20);
    rdchk(8'h00, 8'h00);
    c0 = to_cnt;
    wr(8'h00, 8'h80);
    repeat (30) @(posedge clk);
    chk8(8'(to_cnt - c0), 8'h00);
    rdchk(8'h00, 8'ha0);
    wr(8'h00, 8'h5e);
    rdchk(8'h00, 8'h7e);
    @(posedge clk);
    #1;
    stop_recovery = 1'b1;
    @(posedge clk);
    #1;
    stop_recovery = 1'b0;
    rdchk(8'h00, 8'h3e);
    rdchk(8'h04, 8'h02);
    rdchk(8'hfd, 8'h7d);
    wr(8'h00, 8'h20);
    port_out_data = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk1(timer_output_pin, 1'b1);
    port_out_data = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk1(timer_output_pin, 1'b0);
    // demodulation, falling edge, capture request on
    wr(8'h01, 8'h80);
    c0 = cap_cnt;
    wr(8'h00, 8'h84);
    repeat (40) @(posedge clk);
    #1;
    capture_in = 1'b0;
    wait_pulse(1'b1, t1);
    repeat (2) @(posedge clk);
    chk8(8'(cap_cnt - c0), 8'h01);
    rd(8'h0b, d, h);
    chk_rng(d, 36, 54);
    rdchk(8'h0a, 8'h00);
    rd(8'h08, d2, h);
    chk_rng(d2, 36, 54);
    rdchk(8'h09, 8'h00);
    wr(8'h0b, 8'haa);
    wr(8'h08, 8'h55);
    rdchk(8'h0b, d);
    rdchk(8'h08, d2);
    // rising edge with capture request off
    wr(8'h00, 8'h00);
    wr(8'h01, 8'h90);
    c0 = cap_cnt;
    wr(8'h00, 8'h80);
    repeat (20) @(posedge clk);
    #1;
    capture_in = 1'b1;
    repeat (10) @(posedge clk);
    chk8(8'(cap_cnt - c0), 8'h00);
    rd(8'h0a, d, h);
    chk_rng(d, 16, 34);
    final_report();
  end
endmodule
`default_nettype wire
